// ===== pfm_consts.svh
// Register offsets, field positions, reset values for the port F pin mux
`ifndef PFM_CONSTS_SVH
`define PFM_CONSTS_SVH
`define PFM_ADDR_W          4
`define PFM_OFS_PIN_STATE   4'h0
`define PFM_OFS_OUT_DATA    4'h1
`define PFM_OFS_DIRECTION   4'h2
`define PFM_OFS_BUS_CTRL    4'h3
`define PFM_OFS_MODE        4'h4
`define PFM_BIT_WAIT_PIN_ENABLE       0
`define PFM_BIT_BUS_RELEASE_ENABLE        1
`define PFM_DIR_RST_BUS     8'h80
`define PFM_DIR_RST_SINGLE  8'h00
`define PFM_OUT_DATA_RST    8'h00
`define PFM_MODE_RST        3'h7
`define PFM_PIN_CLK         7
`define PFM_PIN_AS          6
`define PFM_PIN_RD          5
`define PFM_PIN_HWR         4
`define PFM_PIN_LWR         3
`define PFM_PIN_WAIT        2
`define PFM_PIN_GRANT       1
`endif

// ===== pfm_pin_model.sv
// Far-side pin drivers that share the port F wires with the device
`timescale 1ns/1ps
`default_nettype none
module pfm_pin_model (
    input  wire pfm_pkg::pfm_pins_t pins_in,   // Device drive and enables
    input  wire logic [7:0]         ext_in,    // Level the far side offers
    output logic      [7:0]         level_out  // Resolved pin levels
);
    import pfm_pkg::*;
    // Far side yields every pin the device drives, so no contention
    assign level_out = (pins_in.oe & pins_in.val) | (~pins_in.oe & ext_in);
endmodule : pfm_pin_model
`default_nettype wire

// ===== pfm_pkg.sv
// Types for the port F pin mux
`default_nettype none
package pfm_pkg;
    typedef struct packed {
        logic [7:0] oe;
        logic [7:0] val;
    } pfm_pins_t;
    typedef struct packed {
        logic as_n;
        logic rd_n;
        logic hwr_n;
        logic lwr_n;
        logic back_n;
        logic sys_clk;
    } pfm_bus_t;
endpackage : pfm_pkg
`default_nettype wire

// ===== pfm_port_f_mux.sv
// Port F pin function mux with pin-state, data, direction and bus-control registers
// Notes on behaviour
// [RULE1] - The pin-state register is eight bits, read only, and writes to it do nothing.
// [RULE2] - A pin whose direction bit is 1 reads back its output data bit.
// [RULE3] - A pin whose direction bit is 0 reads back the synchronised pin level.
// [RULE4] - Power-on reset and hardware standby reload direction and data, manual reset keeps them.
// [RULE5] - Pin 7 is a port input at direction 0 and the system clock output at 1.
// [RULE6] - Pin 6 drives address strobe in bus modes, else is a port pin by its direction bit.
// [RULE7] - Pin 5 drives read strobe in bus modes, else is a port pin by its direction bit.
// [RULE8] - Pin 4 drives high-byte write strobe in bus modes, else is a port pin.
// [RULE9] - Pin 3 drives low-byte write strobe in bus modes, else is a port pin.
// [RULE10] - Pin 2 is the wait input when wait-enable is set in bus modes, else a port pin.
// [RULE11] - Pin 1 drives bus grant when release-enable is set in bus modes, else a port pin.
// [RULE12] - Pins 3, 2 and 1 always feed external interrupt inputs 3, 2 and 1.
// [RULE13] - Software should leave an interrupt pin as a port input so nothing drives it.
// [RULE14] - The output data register supplies the level of each general-purpose output.
// [RULE15] - Output enables and values follow mode, direction and enables combinationally; here pins_out is registered, one cycle later.
//
// The address map and strobed register access were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "pfm_consts.svh"
module pfm_port_f_mux (
    input  wire logic                   clk_in,           // System clock, 200 MHz
    input  wire logic                   rst_in,           // Async reset, active high
    input  wire logic                   por_in,           // Power-on reset or hw standby, sync
    input  wire logic [`PFM_ADDR_W-1:0] addr_in,          // Register address
    input  wire logic [7:0]             wdata_in,         // Write data
    input  wire logic                   wr_in,            // Write strobe
    input  wire logic                   rd_in,            // Read strobe
    output logic      [7:0]             rdata_out,        // Read data, cycle after read
    input  wire pfm_pkg::pfm_bus_t      bus_in,           // Bus controller strobes and clock
    input  wire logic [7:0]             pin_in,           // Pin levels, asynchronous
    output pfm_pkg::pfm_pins_t          pins_out,         // Pin drive and enables
    output logic                        wait_n_out,       // Wait input to bus controller
    output logic [3:1]                  ext_int_out       // External interrupt inputs 3..1
);
    import pfm_pkg::*;

    logic [7:0] port_f_output_data;
    logic [7:0] port_f_direction;
    logic       wait_pin_enable;
    logic       bus_release_enable;
    logic [2:0] mode;
    logic [7:0] pin_meta;
    logic [7:0] pin_sync;
    logic       por_meta;
    logic       por_sync;

    // Mode is strapped; software may set it, manual reset reloads it to 7
    wire bus_mode = (mode != 3'h3) && (mode != 3'h7) && (mode != 3'h0);
    wire wr_data  = wr_in && (addr_in == `PFM_OFS_OUT_DATA);
    wire wr_dir   = wr_in && (addr_in == `PFM_OFS_DIRECTION);
    wire wr_bctl  = wr_in && (addr_in == `PFM_OFS_BUS_CTRL);
    wire wr_mode  = wr_in && (addr_in == `PFM_OFS_MODE);
    wire [7:0] dir_reset = bus_mode ? `PFM_DIR_RST_BUS : `PFM_DIR_RST_SINGLE;

    // Two-flop synchronisers; only second stage is read
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            pin_meta <= 8'h00;
            pin_sync <= 8'h00;
        end else begin
            pin_meta <= pin_in;
            pin_sync <= pin_meta;
        end
    end

    // Power-on path ignores manual reset so registers load while it is held
    always_ff @(posedge clk_in) begin
        por_meta <= por_in;
        por_sync <= por_meta;
    end

    // rst_in is the manual reset: data, direction and bus-control contents survive it
    always_ff @(posedge clk_in) begin
        if (por_sync) begin
            port_f_output_data <= `PFM_OUT_DATA_RST;                  // [RULE4]
            port_f_direction   <= dir_reset;                          // [RULE4]
            wait_pin_enable    <= 1'b0;
            bus_release_enable <= 1'b0;
        end else begin
            if (wr_data) begin
                port_f_output_data <= wdata_in;                       // [RULE14]
            end
            if (wr_dir) begin
                port_f_direction <= wdata_in;
            end
            if (wr_bctl) begin
                wait_pin_enable    <= wdata_in[`PFM_BIT_WAIT_PIN_ENABLE];
                bus_release_enable <= wdata_in[`PFM_BIT_BUS_RELEASE_ENABLE];
            end
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            mode <= `PFM_MODE_RST;
        end else if (wr_mode) begin
            mode <= wdata_in[2:0];
        end
    end

    // Pin selection per bit
    logic [7:0] next_oe;
    logic [7:0] next_val;
    wire  [7:0] bus_val = {bus_in.sys_clk, bus_in.as_n, bus_in.rd_n, bus_in.hwr_n,
                           bus_in.lwr_n, 1'b1, bus_in.back_n, 1'b0};
    wire  [7:0] bus_own;
    assign bus_own[`PFM_PIN_CLK]   = port_f_direction[`PFM_PIN_CLK];  // [RULE5]
    assign bus_own[`PFM_PIN_AS]    = bus_mode;                        // [RULE6]
    assign bus_own[`PFM_PIN_RD]    = bus_mode;                        // [RULE7]
    assign bus_own[`PFM_PIN_HWR]   = bus_mode;                        // [RULE8]
    assign bus_own[`PFM_PIN_LWR]   = bus_mode;                        // [RULE9]
    assign bus_own[`PFM_PIN_WAIT]  = bus_mode && wait_pin_enable;     // [RULE10]
    assign bus_own[`PFM_PIN_GRANT] = bus_mode && bus_release_enable;  // [RULE11]
    assign bus_own[0]              = 1'b0;
    // Wait pin is an input when owned by the bus controller
    wire  [7:0] bus_drv = bus_own & 8'hfb;

    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1) begin : g_pin
            assign next_oe[g]  = bus_own[g] ? bus_drv[g]
                                            : port_f_direction[g];    // [RULE15]
            assign next_val[g] = bus_own[g] ? bus_val[g]
                                            : port_f_output_data[g];  // [RULE14]
        end
    endgenerate

    // Read mux; direction bit picks data or pin level for pin state
    wire [7:0] pin_state = (port_f_direction & port_f_output_data)    // [RULE2]
                         | (~port_f_direction & pin_sync);            // [RULE3]
    wire [7:0] next_rdata =
        (addr_in == `PFM_OFS_PIN_STATE) ? pin_state :                 // [RULE1]
        (addr_in == `PFM_OFS_OUT_DATA)  ? port_f_output_data :
        (addr_in == `PFM_OFS_BUS_CTRL)  ? {6'h00, bus_release_enable, wait_pin_enable} :
        (addr_in == `PFM_OFS_MODE)      ? {5'h00, mode} : 8'h00;

    // Registered outputs; one cycle of latency on pins
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            pins_out    <= '0;
            rdata_out   <= 8'h00;
            wait_n_out  <= 1'b1;
            ext_int_out <= 3'h7;
        end else begin
            pins_out.oe  <= next_oe;                                  // [RULE15]
            pins_out.val <= next_val;
            rdata_out    <= rd_in ? next_rdata : 8'h00;
            wait_n_out   <= bus_own[`PFM_PIN_WAIT] ? pin_sync[`PFM_PIN_WAIT] : 1'b1;
            ext_int_out  <= pin_sync[3:1];                            // [RULE12]
        end
    end

    // RULE13 binds software; interrupts are taken from the pin regardless of owner.

    property p_as_owned;
        @(posedge clk_in) disable iff (rst_in)
        bus_mode |=> pins_out.oe[`PFM_PIN_AS] && pins_out.val[`PFM_PIN_AS] == $past(bus_in.as_n);
    endproperty
    a_as_owned: assert property (p_as_owned) else $error("address strobe not driven"); // [RULE6]

    property p_rd_port;
        @(posedge clk_in) disable iff (rst_in)
        !bus_mode |=> pins_out.oe[`PFM_PIN_RD] == $past(port_f_direction[`PFM_PIN_RD]);
    endproperty
    a_rd_port: assert property (p_rd_port) else $error("pin 5 direction wrong"); // [RULE7]

    property p_hwr;
        @(posedge clk_in) disable iff (rst_in)
        bus_mode |=> pins_out.val[`PFM_PIN_HWR] == $past(bus_in.hwr_n);
    endproperty
    a_hwr: assert property (p_hwr) else $error("high write strobe wrong"); // [RULE8]

    property p_lwr;
        @(posedge clk_in) disable iff (rst_in)
        bus_mode |=> pins_out.val[`PFM_PIN_LWR] == $past(bus_in.lwr_n);
    endproperty
    a_lwr: assert property (p_lwr) else $error("low write strobe wrong"); // [RULE9]

    property p_wait;
        @(posedge clk_in) disable iff (rst_in)
        (bus_mode && wait_pin_enable) |=> !pins_out.oe[`PFM_PIN_WAIT];
    endproperty
    a_wait: assert property (p_wait) else $error("wait pin driven"); // [RULE10]

    property p_grant;
        @(posedge clk_in) disable iff (rst_in)
        (bus_mode && bus_release_enable) |=> pins_out.val[1] == $past(bus_in.back_n);
    endproperty
    a_grant: assert property (p_grant) else $error("bus grant wrong"); // [RULE11]

    property p_clk7;
        @(posedge clk_in) disable iff (rst_in)
        1'b1 |=> pins_out.oe[7] == $past(port_f_direction[7]);
    endproperty
    a_clk7: assert property (p_clk7) else $error("pin 7 enable wrong"); // [RULE5]

    property p_read;
        @(posedge clk_in) disable iff (rst_in)
        (rd_in && addr_in == `PFM_OFS_PIN_STATE) |=> rdata_out == $past(pin_state);
    endproperty
    a_read: assert property (p_read) else $error("pin state read wrong"); // [RULE2]

    property p_irq;
        @(posedge clk_in) disable iff (rst_in)
        1'b1 |=> ext_int_out == $past(pin_sync[3:1]);
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt input wrong"); // [RULE12]

    property p_por;
        @(posedge clk_in) disable iff (rst_in)
        por_sync |=> port_f_output_data == 8'h00;
    endproperty
    a_por: assert property (p_por) else $error("data not cleared"); // [RULE4]

    property p_por_dir;
        @(posedge clk_in) disable iff (rst_in)
        por_sync |=> port_f_direction == $past(dir_reset);
    endproperty
    a_por_dir: assert property (p_por_dir) else $error("direction not reloaded"); // [RULE4]

    property p_rd_owned;
        @(posedge clk_in) disable iff (rst_in)
        bus_mode |=> pins_out.oe[`PFM_PIN_RD] && pins_out.val[`PFM_PIN_RD] == $past(bus_in.rd_n);
    endproperty
    a_rd_owned: assert property (p_rd_owned) else $error("read strobe not driven"); // [RULE7]

    property p_as_port;
        @(posedge clk_in) disable iff (rst_in)
        !bus_mode |=> pins_out.oe[`PFM_PIN_AS] == $past(port_f_direction[`PFM_PIN_AS]);
    endproperty
    a_as_port: assert property (p_as_port) else $error("pin 6 direction wrong"); // [RULE6]

    property p_hwr_oe;
        @(posedge clk_in) disable iff (rst_in)
        bus_mode |=> pins_out.oe[`PFM_PIN_HWR];
    endproperty
    a_hwr_oe: assert property (p_hwr_oe) else $error("high write strobe not driven"); // [RULE8]

    property p_hwr_port;
        @(posedge clk_in) disable iff (rst_in)
        !bus_mode |=> pins_out.oe[`PFM_PIN_HWR] == $past(port_f_direction[`PFM_PIN_HWR]);
    endproperty
    a_hwr_port: assert property (p_hwr_port) else $error("pin 4 direction wrong"); // [RULE8]

    property p_lwr_oe;
        @(posedge clk_in) disable iff (rst_in)
        bus_mode |=> pins_out.oe[`PFM_PIN_LWR];
    endproperty
    a_lwr_oe: assert property (p_lwr_oe) else $error("low write strobe not driven"); // [RULE9]

    property p_lwr_port;
        @(posedge clk_in) disable iff (rst_in)
        !bus_mode |=> pins_out.oe[`PFM_PIN_LWR] == $past(port_f_direction[`PFM_PIN_LWR]);
    endproperty
    a_lwr_port: assert property (p_lwr_port) else $error("pin 3 direction wrong"); // [RULE9]

    property p_wait_port;
        @(posedge clk_in) disable iff (rst_in)
        !(bus_mode && wait_pin_enable) |=>
            pins_out.oe[`PFM_PIN_WAIT] == $past(port_f_direction[`PFM_PIN_WAIT]);
    endproperty
    a_wait_port: assert property (p_wait_port) else $error("pin 2 direction wrong"); // [RULE10]

    property p_wait_in;
        @(posedge clk_in) disable iff (rst_in)
        (bus_mode && wait_pin_enable) |=> wait_n_out == $past(pin_sync[`PFM_PIN_WAIT]);
    endproperty
    a_wait_in: assert property (p_wait_in) else $error("wait input not passed"); // [RULE10]

    property p_wait_idle;
        @(posedge clk_in) disable iff (rst_in)
        !(bus_mode && wait_pin_enable) |=> wait_n_out;
    endproperty
    a_wait_idle: assert property (p_wait_idle) else $error("wait asserted when unused"); // [RULE10]

    property p_grant_oe;
        @(posedge clk_in) disable iff (rst_in)
        (bus_mode && bus_release_enable) |=> pins_out.oe[`PFM_PIN_GRANT];
    endproperty
    a_grant_oe: assert property (p_grant_oe) else $error("bus grant not driven"); // [RULE11]

    property p_grant_port;
        @(posedge clk_in) disable iff (rst_in)
        !(bus_mode && bus_release_enable) |=>
            pins_out.oe[`PFM_PIN_GRANT] == $past(port_f_direction[`PFM_PIN_GRANT]);
    endproperty
    a_grant_port: assert property (p_grant_port) else $error("pin 1 direction wrong"); // [RULE11]

    property p_clk7_val;
        @(posedge clk_in) disable iff (rst_in)
        port_f_direction[`PFM_PIN_CLK] |=> pins_out.val[`PFM_PIN_CLK] == $past(bus_in.sys_clk);
    endproperty
    a_clk7_val: assert property (p_clk7_val) else $error("system clock not driven"); // [RULE5]

    property p_gpo_val;
        @(posedge clk_in) disable iff (rst_in)
        !bus_mode |=> pins_out.val[6:1] == $past(port_f_output_data[6:1]);
    endproperty
    a_gpo_val: assert property (p_gpo_val) else $error("port output value wrong"); // [RULE14]

    property p_pin0;
        @(posedge clk_in) disable iff (rst_in)
        1'b1 |=> pins_out.oe[0] == $past(port_f_direction[0])
              && pins_out.val[0] == $past(port_f_output_data[0]);
    endproperty
    a_pin0: assert property (p_pin0) else $error("pin 0 drive wrong"); // [RULE14]

    property p_read_idle;
        @(posedge clk_in) disable iff (rst_in)
        !rd_in |=> rdata_out == 8'h00;
    endproperty
    a_read_idle: assert property (p_read_idle) else $error("read data without read"); // [RULE1]

    property p_read_data;
        @(posedge clk_in) disable iff (rst_in)
        (rd_in && addr_in == `PFM_OFS_OUT_DATA) |=> rdata_out == $past(port_f_output_data);
    endproperty
    a_read_data: assert property (p_read_data) else $error("data read wrong"); // [RULE14]

    property p_no_pin_write;
        @(posedge clk_in) disable iff (rst_in)
        (wr_in && addr_in == `PFM_OFS_PIN_STATE && !por_sync) |=>
            $stable(port_f_output_data) && $stable(port_f_direction);
    endproperty
    a_no_pin_write: assert property (p_no_pin_write) else $error("pin state write took"); // [RULE1]

    property p_read_pins;
        @(posedge clk_in) disable iff (rst_in)
        (rd_in && addr_in == `PFM_OFS_PIN_STATE) |=>
            (rdata_out & ~$past(port_f_direction)) == ($past(pin_sync) & ~$past(port_f_direction));
    endproperty
    a_read_pins: assert property (p_read_pins) else $error("pin level read wrong"); // [RULE3]
endmodule : pfm_port_f_mux
`default_nettype wire

// ===== tb_port_f_pin_function_mux.sv
// Self-checking bench for the port F pin mux
`timescale 1ns/1ps
`default_nettype none
`include "pfm_consts.svh"
module tb_port_f_pin_function_mux;
    import pfm_pkg::*;
    logic        clk_in, rst_in, por_in, wr_in, rd_in, chk_p, rd_d, wait_n_out;
    logic [3:0]  addr_in;
    logic [7:0]  wdata_in, rdata_out, ext, lvl, m_dir, m_data;
    logic [3:1]  ext_int_out;
    logic [2:0]  m_mode;
    logic [1:0]  m_bc;
    logic [31:0] r;
    logic [19:0] mq;
    pfm_bus_t    bus_in;
    pfm_pins_t   pins_out, pe;
    logic [19:0] q_pin[$];
    logic [7:0]  q_rd[$];
    int          num_errors = 0, n_checks = 0, cyc = 0;
    wire logic   bm = m_mode inside {3'h1, 3'h2, 3'h4, 3'h5, 3'h6};

    pfm_port_f_mux dut (.clk_in(clk_in), .rst_in(rst_in), .por_in(por_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
        .bus_in(bus_in), .pin_in(lvl), .pins_out(pins_out), .wait_n_out(wait_n_out),
        .ext_int_out(ext_int_out));
    pfm_pin_model far (.pins_in(pins_out), .ext_in(ext), .level_out(lvl));

    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : lfsr
    function automatic pfm_pins_t exp_pins();
        pfm_pins_t p;
        p = {m_dir, m_data};
        p.val[7] = bus_in.sys_clk;
        if (bm) begin
            p.oe[6:3] = 4'hf;
            p.val[6:3] = {bus_in.as_n, bus_in.rd_n, bus_in.hwr_n, bus_in.lwr_n};
            p.oe[2] = p.oe[2] & ~m_bc[0];
            p.oe[1] = p.oe[1] | m_bc[1];
            p.val[1] = m_bc[1] ? bus_in.back_n : p.val[1];
        end
        return p;
    endfunction : exp_pins
    task automatic cmp_pin(input string n, input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        if (e !== g) begin
            num_errors++;
            $display("mismatch %s exp %h got %h", n, e, g);
        end
    endtask : cmp_pin
    task automatic cmp_rd(input logic [7:0] e, input logic [7:0] g);
        cmp_pin("rdata", e, g);
    endtask : cmp_rd
    // One edge per call, so no strobe is assigned twice in a time step
    task automatic drive(input logic [2:0] s, input logic [3:0] a, input logic [7:0] d);
        {wr_in, rd_in, chk_p} <= s;
        addr_in <= a;
        wdata_in <= d;
        @(posedge clk_in);
    endtask : drive
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        drive(3'h4, a, d);
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        q_rd.push_back(e);
        drive(3'h2, a, 8'h00);
    endtask : rd
    task automatic idle(input int n);
        repeat (n) drive(3'h0, 4'h0, 8'h00);
    endtask : idle
    task automatic chk();
        logic [7:0] lv;
        pe = exp_pins();
        lv = (pe.oe & pe.val) | (~pe.oe & ext);
        q_pin.push_back({pe, ~(bm & m_bc[0]) | lv[2], lv[3:1]});
        drive(3'h1, 4'h0, 8'h00);
        rd(`PFM_OFS_PIN_STATE, (m_dir & m_data) | (~m_dir & lv));
    endtask : chk
    task automatic wrap_up();
        if (num_errors == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : wrap_up

    always @(posedge clk_in) begin
        rd_d <= rd_in;
        if (rd_d) cmp_rd(q_rd.pop_front(), rdata_out);
        if (chk_p) begin
            mq = q_pin.pop_front();
            cmp_pin("oe", mq[19:12], pins_out.oe);
            cmp_pin("val", mq[11:4] & mq[19:12], pins_out.val & pins_out.oe);
            cmp_pin("wait_n", {7'h0, mq[3]}, {7'h0, wait_n_out});
            cmp_pin("ext_int", {5'h0, mq[2:0]}, {5'h0, ext_int_out});
        end
    end
    initial begin
        clk_in = 1'b0;
        forever #2.5 clk_in = ~clk_in;
    end
    // Whole run needs under a thousand cycles
    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            num_errors++;
            wrap_up();
        end
    end
    initial begin
        {rst_in, por_in, wr_in, rd_in, chk_p, rd_d} = 6'h30;
        addr_in = 4'h0;
        wdata_in = 8'h00;
        ext = 8'h5a;
        bus_in = '1;
        r = 32'h2b8634bd;
        {m_mode, m_dir, m_data, m_bc} = {3'h7, 18'h0};
        repeat (6) @(posedge clk_in);
        rst_in <= 1'b0;
        idle(4);
        por_in <= 1'b0;
        idle(5);
        chk();
        rd(`PFM_OFS_OUT_DATA, 8'h00);
        for (int i = 0; i < 32; i++) begin
            r = lfsr(r);
            ext <= r[7:0];
            bus_in <= r[13:8];
            {m_dir, m_data, m_mode, m_bc} = {r[31:16], i[2:0], i[4:3]};
            wr(`PFM_OFS_MODE, {5'h0, m_mode});
            wr(`PFM_OFS_DIRECTION, m_dir);
            wr(`PFM_OFS_BUS_CTRL, {6'h0, m_bc});
            wr(`PFM_OFS_OUT_DATA, m_data);
            wr(`PFM_OFS_PIN_STATE, ~m_data);
            wr(4'hf, 8'hff);
            idle(5);
            chk();
            rd(`PFM_OFS_OUT_DATA, m_data);
            rd(`PFM_OFS_DIRECTION, 8'h00);
            rd(4'hf, 8'h00);
        end
        rst_in <= 1'b1;
        idle(2);
        rst_in <= 1'b0;
        m_mode = 3'h7;
        idle(5);
        chk();
        rd(`PFM_OFS_OUT_DATA, m_data);
        por_in <= 1'b1;
        idle(4);
        por_in <= 1'b0;
        {m_dir, m_data, m_bc} = 18'h0;
        idle(5);
        chk();
        rd(`PFM_OFS_OUT_DATA, 8'h00);
        idle(3);
        wrap_up();
    end
endmodule : tb_port_f_pin_function_mux
`default_nettype wire
